// file: bench/lrpd_properties.sv
// port checker for the relay pulse driver top
`timescale 1ns/1ps
module lrpd_properties
  import lrpd_pkg::*;
#(
  parameter int PULSE_CYC = 10
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [1:0]  hresp,
  input wire logic [31:0] relay_drive_bit,
  input wire logic [31:0] spst_drive
);
  logic [7:0]  prev_q;
  logic [23:0] run_q;
  logic        wr_q;
  wire  logic  take = hsel && hready && htrans[1];
  wire  logic [7:0] ln = relay_drive_bit[7:0];
  // ============================================================
  // helpers: run length of the lane 0 drive value, and a flag for writes to the spst register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 8'h00;
      run_q  <= 24'h0;
      wr_q   <= 1'b0;
    end else begin
      prev_q <= ln;
      run_q  <= (ln == prev_q) ? run_q + 24'h1 : 24'h0;
      wr_q   <= take && hwrite && haddr[7:0] == OFS_SPST;
    end
  end
  // ============================================================
  // properties
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_boot_quiet: assert property (
    !$past(hresetn) |-> (relay_drive_bit == 32'h0)[*3])
    else $error("coil driven after reset");
  a_pulse_len: assert property (
    prev_q != 8'h00 && ln != prev_q |-> run_q == PULSE_CYC - 1)
    else $error("coil pulse length wrong");
  a_clear_first: assert property (
    prev_q == 8'h00 && ln != 8'h00 |-> ln == 8'h40)
    else $error("set before clear");
  a_set_one_line: assert property (
    prev_q == 8'h40 && ln != 8'h40 |->
    ln[7:6] == 2'b00 && $onehot(ln[5:0]))
    else $error("set phase not one line");
  a_read_wait: assert property (
    take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (
    take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (
    hresp == 2'h0)
    else $error("response not okay");
  a_spst_only_write: assert property (
    $changed(spst_drive) |-> $past(wr_q) || $past(wr_q, 2))
    else $error("spst moved without write");
endmodule

bind lrpd_top lrpd_properties u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .relay_drive_bit(relay_drive_bit), .spst_drive(spst_drive)
);

// file: bench/lrpd_relay_model.sv
// latching coils with spare indicator contacts
`timescale 1ns/1ps
module lrpd_relay_model
  import lrpd_pkg::*;
(
  input  wire logic [31:0] coil,
  input  wire logic [7:0]  lane_mode,
  output logic      [31:0] readback_bit
);
  initial readback_bit = 32'h0;
  // ============================================================
  // throws move only under coil current, so they survive resets
  always @(coil) begin
    for (int l = 0; l < NUM_LANES; l++) begin
      for (int k = 0; k < LANE_W; k++) begin
        if (coil[8*l+k] && lane_mode[2*l+:2] == MODE_SIXWAY) begin
          if (k == RESET_BIT)
            readback_bit[8*l+:POS_LINES] = '0;
          else if (k < POS_LINES)
            readback_bit[8*l+k] = 1'b1;
        end else if (coil[8*l+k]) begin
          readback_bit[8*l+k] = 1'b1;
          readback_bit[8*l+(k^1)] = 1'b0;
        end
      end
    end
  end
endmodule

// file: bench/test_latching_relay_pulse_driver.sv
// self-checking bench for the relay pulse driver
`timescale 1ns/1ps
module test_latching_relay_pulse_driver;
  import lrpd_pkg::*;
  typedef struct packed {
    logic [7:0]  mode;
    logic [31:0] cmd;
    logic [1:0]  lane;
    logic [7:0]  clrv;
    logic [7:0]  setv;
    logic [7:0]  back;
  } lrpd_row_type;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  lane_mode = 8'h55;
  logic        hready, hreadyout;
  logic [1:0]  hresp;
  logic [31:0] hrdata, relay_drive_bit, spst_drive, readback_bit, rd;
  int          n_mismatch = 0;
  int          compares = 0;
  lrpd_row_type rows [8] = '{
    '{8'h55, 32'h04, 2'h0, 8'h40, 8'h04, 8'h04},
    '{8'h55, 32'h20, 2'h0, 8'h40, 8'h20, 8'h20},
    '{8'h55, 32'h20, 2'h0, 8'h40, 8'h20, 8'h20},
    '{8'h55, 32'h03, 2'h0, 8'h40, 8'h01, 8'h01},
    '{8'h55, 32'h0200_0000, 2'h3, 8'h40, 8'h02, 8'h02},
    '{8'h59, 32'h0100, 2'h1, 8'h02, 8'h01, 8'h01},
    '{8'h59, 32'h0200, 2'h1, 8'h01, 8'h02, 8'h02},
    '{8'h35, 32'h0010_0000, 2'h2, 8'h20, 8'h10, 8'h10}};

  always #50 hclk = ~hclk;
  assign hready = hreadyout;

  lrpd_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .relay_drive_bit(relay_drive_bit), .spst_drive(spst_drive),
    .readback_bit(readback_bit));
  lrpd_relay_model u_relays (
    .coil(relay_drive_bit), .lane_mode(lane_mode),
    .readback_bit(readback_bit));

  // ============================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // one clear-then-set run on a lane, 10-cycle pulses
  task automatic seq(input int l, input logic [7:0] c,
                     input logic [7:0] s);
    int i;
    i = 0;
    while (relay_drive_bit[8*l+:8] == 8'h0 && i < 40) begin
      @(posedge hclk);
      #1;
      i++;
    end
    chk("clear", 32'(c), 32'(relay_drive_bit[8*l+:8]));
    repeat (10) @(posedge hclk);
    #1;
    chk("set", 32'(s), 32'(relay_drive_bit[8*l+:8]));
    repeat (10) @(posedge hclk);
    #1;
    chk("end", 32'h0, 32'(relay_drive_bit[8*l+:8] & s));
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ============================================================
  // tests
  initial begin
    repeat (5000) @(posedge hclk);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, OFS_DELAY, 32'h0);
    chk("delay", 32'(DELAY_RESET), rd);
    bus(1'b0, OFS_LANE_MODE, 32'h0);
    chk("mode", 32'(LANE_MODE_RESET), rd);
    bus(1'b0, 8'h1C, 32'h0);
    chk("hole", 32'h0, rd);
    $display("reset values done");
    bus(1'b1, OFS_DELAY, 32'h1);
    foreach (rows[r]) begin
      lane_mode <= rows[r].mode;
      bus(1'b1, OFS_LANE_MODE, 32'(rows[r].mode));
      bus(1'b1, OFS_LATCH_CMD, rows[r].cmd);
      seq(rows[r].lane, rows[r].clrv, rows[r].setv);
      repeat (6) @(posedge hclk);
      bus(1'b0, OFS_READBACK, 32'h0);
      chk("back", 32'(rows[r].back), 32'(rd[8*rows[r].lane+:8]));
      $display("row %0d done", r);
    end
    bus(1'b1, OFS_LATCH_CMD, 32'h04);
    fork
      seq(0, 8'h40, 8'h04);
      begin
        repeat (2) @(posedge hclk);
        bus(1'b1, OFS_LATCH_CMD, 32'h10);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("status", 32'h11, rd);
      end
    join
    seq(0, 8'h40, 8'h10);
    $display("held command done");
    bus(1'b1, OFS_SPST, 32'hA5C3_0FF0);
    repeat (2) @(posedge hclk);
    #1;
    chk("spst", 32'hA5C3_0FF0, spst_drive);
    @(posedge hclk);
    hresetn <= 1'b0;
    lane_mode <= 8'h55;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (20) @(posedge hclk);
    bus(1'b0, OFS_READBACK, 32'h0);
    chk("kept", 32'h0210_0210, rd);
    bus(1'b1, OFS_DELAY, 32'h1);
    bus(1'b1, OFS_LATCH_CMD, 32'h01);
    seq(0, 8'h40, 8'h01);
    $display("reset recovery done");
    // slot four declared empty: its byte must be dropped
    lane_mode <= 8'h15;
    bus(1'b1, OFS_LANE_MODE, 32'h15);
    bus(1'b1, OFS_LATCH_CMD, 32'h0100_0020);
    bus(1'b0, OFS_COIL, 32'h0);
    chk("coil", 32'h40, rd);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h01, rd);
    repeat (25) @(posedge hclk);
    bus(1'b0, OFS_LATCH_CMD, 32'h0);
    chk("latch", 32'h0100_0020, rd);
    $display("empty slot done");
    tally_and_finish();
  end
endmodule

// file: hdl/lrpd_lane_seq.sv
// clear-then-set coil pulse sequencer for one eight-bit drive lane
`timescale 1ns/1ps
module lrpd_lane_seq
  import lrpd_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              cmd_valid,
  input  wire logic [LANE_W-1:0] cmd_byte,
  input  wire logic [MODE_W-1:0] mode,
  input  wire logic [CNT_W-1:0]  pulse_cycles,
  output logic      [LANE_W-1:0] coil_q,
  output logic                   busy_q,
  output logic                   pend_q
);

  lrpd_state_type   state_q;
  logic [LANE_W-1:0] pend_byte_q;
  logic [LANE_W-1:0] set_vec_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [2*LANE_W-1:0] dec;

  // returns {clear lines, set lines}
  function automatic logic [2*LANE_W-1:0] decode(
    input logic [MODE_W-1:0] m,
    input logic [LANE_W-1:0] b
  );
    logic [LANE_W-1:0] clr;
    logic [LANE_W-1:0] set;
    logic              found;
    clr   = '0;
    set   = '0;
    found = 1'b0;
    if (m == MODE_SIXWAY) begin
      // lowest requested position wins; reset line clears the old one
      for (int i = 0; i < POS_LINES; i++) begin
        if (b[i] && !found) begin
          set[i] = 1'b1;
          found  = 1'b1;
        end
      end
      clr[RESET_BIT] = found;
    end else if (m == MODE_PAIR4 || m == MODE_PAIR3) begin
      for (int p = 0; p < LANE_W / 2; p++) begin
        if (m == MODE_PAIR4 || p < 3) begin
          if (b[2*p]) begin
            clr[2*p+1] = 1'b1;
            set[2*p]   = 1'b1;
          end else if (b[2*p+1]) begin
            clr[2*p]   = 1'b1;
            set[2*p+1] = 1'b1;
          end
        end
      end
    end
    return {clr, set};
  endfunction

  assign dec = decode(mode, pend_byte_q);

  // new command always overrides the clear of the pending flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q      <= 1'b0;
      pend_byte_q <= '0;
    end else if (cmd_valid) begin
      pend_q      <= 1'b1;
      pend_byte_q <= cmd_byte;
    end else if (state_q == ST_IDLE) begin
      pend_q <= 1'b0;
    end
  end

  // reset leaves every coil released: no clearing pulse at power-up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= ST_IDLE;
      coil_q    <= '0;
      set_vec_q <= '0;
      cnt_q     <= '0;
      busy_q    <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (pend_q && !cmd_valid && dec[LANE_W-1:0] != '0) begin
            coil_q    <= dec[2*LANE_W-1:LANE_W];
            set_vec_q <= dec[LANE_W-1:0];
            cnt_q     <= pulse_cycles - CNT_W'(1);
            busy_q    <= 1'b1;
            state_q   <= ST_CLEAR;
          end
        end
        ST_CLEAR: begin
          if (cnt_q == '0) begin
            coil_q  <= set_vec_q;
            cnt_q   <= pulse_cycles - CNT_W'(1);
            state_q <= ST_SET;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        ST_SET: begin
          if (cnt_q == '0) begin
            coil_q  <= '0;
            busy_q  <= 1'b0;
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        default: begin
          coil_q  <= '0;
          busy_q  <= 1'b0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// file: hdl/lrpd_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module lrpd_sync
  import lrpd_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_q
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per bit: accept a change only once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_q <= '0;
    end else begin
      sync_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & sync_q);
    end
  end

endmodule

// file: hdl/lrpd_top.sv
// ahb-lite register slave and coil drive top for the relay card
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module lrpd_top
  import lrpd_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic      [1:0]  hresp,
  output logic      [31:0] relay_drive_bit,
  output logic      [31:0] spst_drive,
  input  wire logic [31:0] readback_bit
);

  // ============================================================
  // bus address and data phase tracking
  logic                 wr_pend_q;
  logic                 rd_pend_q;
  logic [7:0]           addr_q;
  logic [31:0]          hrdata_q;
  logic                 hreadyout_q;
  logic [1:0]           hresp_q;
  logic                 accept;

  // ============================================================
  // registers
  logic [31:0]          latch_cmd_q;
  logic [DELAY_W-1:0]   delay_q;
  logic [7:0]           lane_mode_q;
  logic [31:0]          spst_q;
  logic [NUM_LANES-1:0] cmd_valid_q;
  logic [CNT_W-1:0]     pulse_cycles_q;

  // ============================================================
  // lane and readback wiring
  logic [31:0]          coil;
  logic [NUM_LANES-1:0] busy;
  logic [NUM_LANES-1:0] pend;
  logic [31:0]          readback_sync;

  assign accept = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= '0;
    end else if (hready || hreadyout_q) begin
      wr_pend_q <= accept && hwrite;
      rd_pend_q <= accept && !hwrite;
      addr_q    <= haddr[7:0];
    end else begin
      rd_pend_q <= 1'b0;
    end
  end

  // reads take one wait state so the data reflect a write just before
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
    end else if (accept && !hwrite && hreadyout_q) begin
      hreadyout_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_q <= HRESP_OKAY;
    end else begin
      hresp_q <= HRESP_OKAY;
    end
  end

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    logic [31:0] d;
    d = '0;
    case (a)
      OFS_LATCH_CMD: d = latch_cmd_q;
      OFS_STATUS:    d = {24'h000000, pend, busy};
      OFS_DELAY:     d = {16'h0000, delay_q};
      OFS_LANE_MODE: d = {24'h000000, lane_mode_q};
      OFS_SPST:      d = spst_q;
      OFS_READBACK:  d = readback_sync;
      OFS_COIL:      d = coil;
      default:       d = '0;
    endcase
    return d;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
    end else if (rd_pend_q && !hreadyout_q) begin
      hrdata_q <= read_mux(addr_q);
    end
  end

  // ============================================================
  // register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_cmd_q <= '0;
      cmd_valid_q <= '0;
    end else begin
      cmd_valid_q <= '0;
      if (wr_pend_q && addr_q == OFS_LATCH_CMD) begin
        latch_cmd_q <= hwdata;
        // a zero byte leaves that lane alone
        for (int l = 0; l < NUM_LANES; l++) begin
          cmd_valid_q[l] <= hwdata[l*LANE_W +: LANE_W] != '0;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      delay_q <= DELAY_RESET;
    end else if (wr_pend_q && addr_q == OFS_DELAY) begin
      delay_q <= hwdata[DELAY_W-1:0];
    end
  end

  // slot layout is software's to declare after a module swap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lane_mode_q <= LANE_MODE_RESET;
    end else if (wr_pend_q && addr_q == OFS_LANE_MODE) begin
      lane_mode_q <= hwdata[7:0];
    end
  end

  // non-latching bank simply follows its bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spst_q <= '0;
    end else if (wr_pend_q && addr_q == OFS_SPST) begin
      spst_q <= hwdata;
    end
  end

  // zero delay would wrap the pulse counter to its maximum; one unit is the floor
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_cycles_q <= CNT_W'(CYC_PER_UNIT);
    end else if (delay_q == '0) begin
      pulse_cycles_q <= CNT_W'(CYC_PER_UNIT);
    end else begin
      pulse_cycles_q <= CNT_W'(delay_q) * CNT_W'(CYC_PER_UNIT);
    end
  end

  // ============================================================
  // one sequencer per eight-bit slot
  for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
    lrpd_lane_seq u_seq (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .cmd_valid    (cmd_valid_q[g]),
      .cmd_byte     (latch_cmd_q[g*LANE_W +: LANE_W]),
      .mode         (lane_mode_q[g*MODE_W +: MODE_W]),
      .pulse_cycles (pulse_cycles_q),
      .coil_q       (coil[g*LANE_W +: LANE_W]),
      .busy_q       (busy[g]),
      .pend_q       (pend[g])
    );
  end

  lrpd_sync #(.WIDTH(32)) u_rb_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (readback_bit),
    .sync_q   (readback_sync)
  );

  assign hrdata          = hrdata_q;
  assign hreadyout       = hreadyout_q;
  assign hresp           = hresp_q;
  assign relay_drive_bit = coil;
  assign spst_drive      = spst_q;

endmodule

// file: shared/lrpd_pkg.sv
// constants, types and register map for the latching relay pulse driver
// ============================================================
// Function
// - latching coil pulsed for programmed delay only
// - clear old position, then set new
// - reselecting a set position reruns clear-set
// - status read from spare indicator contacts
// - six-way slot: six lines, reset, six readbacks
// - forty GHz: up to four eight-bit slots
// - twelve two-position switches on bits 1-24
// - mixed: two six-way slots, three pairs
// - separate non-latching bank held while set
// - no clearing pulses at power-up or reset
// - slot layout set by software, no identifier
package lrpd_pkg;

  // ============================================================
  // timing
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned DELAY_UNIT_NS = 1000;
  localparam int unsigned CYC_PER_UNIT  =
    (CLK_HZ / 1_000_000) * DELAY_UNIT_NS / 1000;
  localparam int          CNT_W         = 24;
  localparam int          DELAY_W       = 16;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 16'h3A98;

  // ============================================================
  // register byte offsets
  localparam logic [7:0] OFS_LATCH_CMD = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_DELAY     = 8'h08;
  localparam logic [7:0] OFS_LANE_MODE = 8'h0C;
  localparam logic [7:0] OFS_SPST      = 8'h10;
  localparam logic [7:0] OFS_READBACK  = 8'h14;
  localparam logic [7:0] OFS_COIL      = 8'h18;

  // ============================================================
  // lane layout
  localparam int NUM_LANES = 4;
  localparam int LANE_W    = 8;
  localparam int POS_LINES = 6;
  localparam int RESET_BIT = 6;
  localparam int MODE_W    = 2;
  localparam logic [7:0] LANE_MODE_RESET = 8'h55;

  localparam logic [MODE_W-1:0] MODE_NONE   = 2'h0;
  localparam logic [MODE_W-1:0] MODE_SIXWAY = 2'h1;
  localparam logic [MODE_W-1:0] MODE_PAIR4  = 2'h2;
  localparam logic [MODE_W-1:0] MODE_PAIR3  = 2'h3;

  // ============================================================
  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY    = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CLEAR,
    ST_SET
  } lrpd_state_type;

endpackage
